// ==== logic/swlc_consts.svh ====
/*
 Constants of the serial wiper latch controller: word layout, midscale code,
 channel count and serial timing figures.
 Assumes a 20 MHz system clock that samples the serial pins.
*/
// Function
// - Host shifts ten bits or more per frame; device captures them serially.
// - Word is two address bits then eight data bits, both MSB first.
// - Address bits pick one latch; channel = high*2 + low.
// - Channels update independently in any order; others stay untouched.
// - Serial link accepts shift clocks up to 10 MHz, 100 ns per bit.
// - Latches hold no defined value after power-up; no automatic preset.
// - Active-low reset forces every latch to midscale code 128.
// - Shutdown opens every top terminal and ties wiper to bottom terminal.
// - Shutdown keeps latch contents; wipers return to retained codes after.
// - Serial input keeps working in shutdown; chained output is disabled.
// - Words loaded during shutdown update latches, shown after release.
// - Each latch holds an 8-bit code selecting one of 256 taps.
// - Code zero selects tap nearest bottom terminal; each step moves up.
// - While chip select low, shift one bit per rising serial clock edge.
// - On chip select rise keep the last ten bits shifted in.
// - Addressed latch loads the final eight bits of the captured word.
// - Chained output presents the bit entered ten shifts earlier.
`ifndef SWLC_CONSTS_SVH
`define SWLC_CONSTS_SVH

`define SWLC_WORD_BITS     10
`define SWLC_CODE_BITS     8
`define SWLC_ADDR_BITS     2
`define SWLC_NUM_CHAN      4
`define SWLC_TAPS          256
`define SWLC_ADDR_MSB      9
`define SWLC_ADDR_LSB      8
`define SWLC_CODE_MSB      7
`define SWLC_MIDSCALE      8'h80
`define SWLC_CODE_ZERO     8'h00
`define SWLC_WORD_ZERO     10'h000
`define SWLC_SCLK_MAX_MHZ  10
`define SWLC_BIT_TIME_NS   100
`define SWLC_SYS_CLK_MHZ   20
// Reset levels of the pin synchronisers: serial pins idle, control pins
// reading as shutdown to match the reset state of the terminal outputs
`define SWLC_PIN_SYNC_RST  3'h7
`define SWLC_CTL_SYNC_RST  2'h2

`endif

// ==== logic/swlc_pkg.sv ====
/*
 Types of the serial wiper latch controller.
 Assumes swlc_consts.svh is on the include path.
*/
`include "swlc_consts.svh"

package swlc_pkg;
    typedef logic [`SWLC_CODE_BITS-1:0] swlc_code_t;
    typedef logic [`SWLC_WORD_BITS-1:0] swlc_word_t;
    typedef logic [`SWLC_ADDR_BITS-1:0] swlc_addr_t;
    typedef logic [`SWLC_TAPS-1:0]      swlc_taps_t;

    typedef enum logic [1:0] {
        SWLC_IDLE  = 2'h0,
        SWLC_SHIFT = 2'h1,
        SWLC_LOAD  = 2'h3
    } swlc_state_t;

    // Channel index from the two address bits
    function automatic swlc_addr_t swlc_chan(input swlc_word_t w);
        return w[`SWLC_ADDR_MSB:`SWLC_ADDR_LSB];
    endfunction
endpackage

// ==== logic/swlc_word_if.sv ====
/*
 Carrier between the serial front end and the latch bank: a captured word
 and a one-cycle load strobe.
 Assumes both ends run on the system clock.
*/
`timescale 1ns/10ps

interface swlc_word_if;
    import swlc_pkg::*;
    logic       load;
    swlc_word_t word;

    modport src (output load, output word);
    modport dst (input load, input word);
endinterface

// ==== logic/swlc_serial_rx.sv ====
/*
 Serial front end: samples the serial pins through two flip-flops, finds
 serial clock rising edges and chip select rising edges, shifts the word and
 drives the chained output.
 Assumes the serial clock is at most 10 MHz, so a 20 MHz sample sees each level.
*/
`timescale 1ns/10ps
`include "swlc_consts.svh"

module swlc_serial_rx
    import swlc_pkg::*;
(
    // Clock and reset
    input  wire logic   i_clk,
    input  wire logic   i_reset_n,
    // Serial pins
    input  wire logic   i_sclk,
    input  wire logic   i_cs_n,
    input  wire logic   i_serial_word_in,
    // Word to latch bank
    swlc_word_if.src    word_o,
    // Chained data bit
    output logic        o_chain_bit
);
    // ========================================
    // Synchronisers
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic       sclk_prev_q;
    logic       cs_prev_q;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            sync1_q     <= `SWLC_PIN_SYNC_RST;
            sync2_q     <= `SWLC_PIN_SYNC_RST;
            sclk_prev_q <= 1'b1;
            cs_prev_q   <= 1'b1;
        end else begin
            sync1_q     <= {i_sclk, i_cs_n, i_serial_word_in};
            sync2_q     <= sync1_q;
            sclk_prev_q <= sync2_q[2];
            cs_prev_q   <= sync2_q[1];
        end
    end

    logic sclk_rise;
    logic cs_rise;
    logic cs_low;
    assign cs_low    = !sync2_q[1];
    assign sclk_rise = sync2_q[2] && !sclk_prev_q;
    assign cs_rise   = sync2_q[1] && !cs_prev_q;

    // ========================================
    // State machine
    swlc_state_t state_q;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_q <= SWLC_IDLE;
        end else begin
            case (state_q)
                SWLC_IDLE:  if (cs_low) state_q <= SWLC_SHIFT;
                SWLC_SHIFT: if (cs_rise) state_q <= SWLC_LOAD;
                SWLC_LOAD:  state_q <= SWLC_IDLE;
                default:    state_q <= SWLC_IDLE;
            endcase
        end
    end

    // ========================================
    // Shift register, MSB first, ten bits deep
    swlc_word_t shift_q;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            shift_q <= `SWLC_WORD_ZERO;
        end else if (cs_low && sclk_rise) begin
            shift_q <= {shift_q[`SWLC_WORD_BITS-2:0], sync2_q[0]};
        end
    end

    // Bit leaving the register is the one entered ten shifts earlier
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_chain_bit <= 1'b0;
        end else if (cs_low && sclk_rise) begin
            o_chain_bit <= shift_q[`SWLC_WORD_BITS-1];
        end
    end

    // ========================================
    // Captured word and load strobe
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            word_o.word <= `SWLC_WORD_ZERO;
            word_o.load <= 1'b0;
        end else begin
            word_o.load <= (state_q == SWLC_SHIFT) && cs_rise;
            if ((state_q == SWLC_SHIFT) && cs_rise) begin
                word_o.word <= shift_q;
            end
        end
    end
endmodule // swlc_serial_rx

// ==== logic/swlc_latch_bank.sv ====
/*
 Four wiper code latches, loaded from captured words and preset to midscale
 by the midscale reset.
 Assumes the midscale reset has already been synchronised.
*/
`timescale 1ns/10ps
`include "swlc_consts.svh"

module swlc_latch_bank
    import swlc_pkg::*;
(
    // Clock; no reset
    input  wire logic   i_clk,
    // Midscale preset, synchronised
    input  wire logic   i_midscale,
    // Word from serial front end
    swlc_word_if.dst    word_i,
    // Latch contents
    output swlc_code_t  o_code [`SWLC_NUM_CHAN]
);
    // No i_reset_n here: latches hold no defined value at power-up
    swlc_code_t wiper_code_latch_q [`SWLC_NUM_CHAN];

    always_ff @(posedge i_clk) begin
        for (int c = 0; c < `SWLC_NUM_CHAN; c++) begin
            if (i_midscale) begin
                wiper_code_latch_q[c] <= `SWLC_MIDSCALE;
            end else if (word_i.load && (swlc_chan(word_i.word) == c[`SWLC_ADDR_BITS-1:0])) begin
                wiper_code_latch_q[c] <= word_i.word[`SWLC_CODE_MSB:0];
            end
        end
    end

    assign o_code = wiper_code_latch_q;
endmodule // swlc_latch_bank

// ==== logic/serial_wiper_latch_ctrl.sv ====
/*
 Top of the serial wiper latch controller: serial front end, latch bank,
 tap decode and shutdown switching of the four channels.
 Assumes i_clk at 20 MHz; serial pins, midscale reset and power-down pins are
 asynchronous and are synchronised here.
*/
`timescale 1ns/10ps
`include "swlc_consts.svh"

module serial_wiper_latch_ctrl
    import swlc_pkg::*;
(
    // Clock and reset
    input  wire logic   i_clk,
    input  wire logic   i_reset_n,
    // Serial link
    input  wire logic   i_sclk,
    input  wire logic   i_cs_n,
    input  wire logic   i_serial_word_in,
    output logic        o_chain_word_out,
    output logic        o_chain_word_out_oe_n,
    // Control pins
    input  wire logic   i_midscale_reset_n,
    input  wire logic   i_power_down_n,
    // Channel state
    output swlc_code_t  o_wiper_code [`SWLC_NUM_CHAN],
    output swlc_taps_t  o_tap_select [`SWLC_NUM_CHAN],
    output logic [`SWLC_NUM_CHAN-1:0] o_top_terminal_open,
    output logic [`SWLC_NUM_CHAN-1:0] o_wiper_to_bottom
);
    // ========================================
    // Control pin synchronisers
    logic [1:0] ctl_s1_q;
    logic [1:0] ctl_s2_q;
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ctl_s1_q <= `SWLC_CTL_SYNC_RST;
            ctl_s2_q <= `SWLC_CTL_SYNC_RST;
        end else begin
            ctl_s1_q <= {i_midscale_reset_n, i_power_down_n};
            ctl_s2_q <= ctl_s1_q;
        end
    end

    logic midscale;
    logic shutdown;
    assign midscale = !ctl_s2_q[1];
    assign shutdown = !ctl_s2_q[0];

    // ========================================
    // Serial front end and latches
    swlc_word_if word_bus ();
    logic        chain_bit;
    swlc_code_t  code [`SWLC_NUM_CHAN];

    swlc_serial_rx u_rx (
        .i_clk            (i_clk),
        .i_reset_n        (i_reset_n),
        .i_sclk           (i_sclk),
        .i_cs_n           (i_cs_n),
        .i_serial_word_in (i_serial_word_in),
        .word_o           (word_bus),
        .o_chain_bit      (chain_bit)
    );

    swlc_latch_bank u_bank (
        .i_clk      (i_clk),
        .i_midscale (midscale),
        .word_i     (word_bus),
        .o_code     (code)
    );

    // ========================================
    // Chained output: open-drain style, released in shutdown
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_chain_word_out      <= 1'b0;
            o_chain_word_out_oe_n <= 1'b1;
        end else begin
            o_chain_word_out      <= 1'b0;
            o_chain_word_out_oe_n <= shutdown || midscale || chain_bit;
        end
    end

    // ========================================
    // Tap decode and shutdown switching
    function automatic swlc_taps_t tap_onehot(input swlc_code_t c);
        swlc_taps_t t;
        t    = '0;
        t[c] = 1'b1;
        return t;
    endfunction

    always_ff @(posedge i_clk) begin
        for (int c = 0; c < `SWLC_NUM_CHAN; c++) begin
            o_wiper_code[c] <= code[c];
            o_tap_select[c] <= shutdown ? '0 : tap_onehot(code[c]);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_top_terminal_open <= '1;
            o_wiper_to_bottom   <= '1;
        end else begin
            o_top_terminal_open <= {`SWLC_NUM_CHAN{shutdown}};
            o_wiper_to_bottom   <= {`SWLC_NUM_CHAN{shutdown}};
        end
    end
endmodule // serial_wiper_latch_ctrl

// ==== verif/swlc_props.sv ====
/*
 Checker of the serial wiper latch controller, bound to its top ports.
 Assumes one i_clk domain and a synchronous active-low i_reset_n.
*/
`timescale 1ns/10ps
`include "swlc_consts.svh"

module swlc_props
    import swlc_pkg::*;
(
    // Clock and reset
    input wire logic  i_clk,
    input wire logic  i_reset_n,
    // Control pins
    input wire logic  i_cs_n,
    input wire logic  i_midscale_reset_n,
    input wire logic  i_power_down_n,
    // Outputs watched
    input wire logic  o_chain_word_out_oe_n,
    input swlc_code_t o_wiper_code [`SWLC_NUM_CHAN],
    input swlc_taps_t o_tap_select [`SWLC_NUM_CHAN],
    input wire logic [`SWLC_NUM_CHAN-1:0] o_top_terminal_open,
    input wire logic [`SWLC_NUM_CHAN-1:0] o_wiper_to_bottom
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // ==========================================
    // Assertions
    AST_TOP_OPEN: assert property ((!i_power_down_n)[*5] |-> &o_top_terminal_open)
        else $error("top terminals not open in shutdown");
    AST_WIPER_LOW: assert property ((!i_power_down_n)[*5] |-> &o_wiper_to_bottom)
        else $error("wipers not tied to bottom in shutdown");
    AST_TAP_OFF: assert property ((!i_power_down_n)[*5] |-> o_tap_select[3] == 256'h0)
        else $error("tap selected in shutdown");
    AST_POWER_DOWN_N_OE: assert property ((!i_power_down_n)[*4] |-> o_chain_word_out_oe_n)
        else $error("chain output driven in shutdown");
    AST_MIDSCALE: assert property ((!i_midscale_reset_n)[*5] |-> o_wiper_code[2] == `SWLC_MIDSCALE)
        else $error("latch not at midscale");
    AST_TAP_ONEHOT: assert property ((i_power_down_n)[*5] |-> o_tap_select[0] == (256'h1 << o_wiper_code[0]))
        else $error("tap does not match code");
    AST_CODE_QUIET: assert property ((!i_cs_n && i_midscale_reset_n)[*8] |=> $stable(o_wiper_code[1]))
        else $error("code changed inside a frame");
    AST_CHAIN_HOLD: assert property ((i_cs_n && i_power_down_n && i_midscale_reset_n)[*5]
        |=> $stable(o_chain_word_out_oe_n))
        else $error("chain output moved without a shift");

    cover property ($rose(i_cs_n));
    cover property ($fell(i_power_down_n));
    cover property ($fell(i_midscale_reset_n));
endmodule // swlc_props

bind serial_wiper_latch_ctrl swlc_props swlc_props_inst (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_cs_n(i_cs_n),
    .i_midscale_reset_n(i_midscale_reset_n), .i_power_down_n(i_power_down_n),
    .o_chain_word_out_oe_n(o_chain_word_out_oe_n), .o_wiper_code(o_wiper_code),
    .o_tap_select(o_tap_select), .o_top_terminal_open(o_top_terminal_open),
    .o_wiper_to_bottom(o_wiper_to_bottom));

// ==== verif/swlc_host_model.sv ====
/*
 Host master of the serial link: frames words, records the chained line.
 Assumes i_clk at 20 MHz; makes a 600 ns serial clock that idles low.
*/
`timescale 1ns/10ps
`include "swlc_consts.svh"

module swlc_host_model
    import swlc_pkg::*;
(
    // Clock
    input  wire logic i_clk,
    // Chained line level
    input  wire logic i_chain_level,
    // Serial link
    output logic      o_sclk,
    output logic      o_cs_n,
    output logic      o_serial_word_in
);
    localparam swlc_word_t JUNK = 10'h2c5;
    swlc_word_t chain_q = `SWLC_WORD_ZERO;

    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_serial_word_in = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // ==========================================
    // One frame: optional ten junk bits, then the word; quad part, any address
    task automatic send_word(input swlc_word_t w, input logic junk);
        swlc_word_t bits [2];
        bits[0] = JUNK;
        bits[1] = w;
        o_cs_n <= 1'b0;
        tick(4);
        for (int k = junk ? 0 : 10; k < 20; k++) begin
            o_serial_word_in <= bits[k / 10][9 - k % 10];
            tick(4);
            o_sclk <= 1'b1;
            tick(4);
            o_sclk <= 1'b0;
            tick(4);
            chain_q <= {chain_q[8:0], i_chain_level};
        end
        o_cs_n <= 1'b1;
        o_serial_word_in <= ~o_serial_word_in;
        tick(4);
    endtask
endmodule // swlc_host_model

// ==== verif/tb_top.sv ====
/*
 Self-checking bench of the serial wiper latch controller.
 Assumes the design, the checker and the host model are compiled first.
*/
`timescale 1ns/10ps
`include "swlc_consts.svh"

module tb_top;
    import swlc_pkg::*;
    logic       clk, reset_n, mid_n, pd_n, sclk, cs_n, serial_word_in, chain_word_out, sdo_oe_n;
    logic [3:0] top_open, to_bottom;
    swlc_code_t code [`SWLC_NUM_CHAN];
    swlc_taps_t taps [`SWLC_NUM_CHAN];
    swlc_code_t exp [`SWLC_NUM_CHAN];
    int         fails = 0;
    int         samples_checked = 0;
    int         cycles = 0;

    serial_wiper_latch_ctrl serial_wiper_latch_ctrl_inst (
        .i_clk(clk), .i_reset_n(reset_n), .i_sclk(sclk), .i_cs_n(cs_n),
        .i_serial_word_in(serial_word_in), .o_chain_word_out(chain_word_out), .o_chain_word_out_oe_n(sdo_oe_n),
        .i_midscale_reset_n(mid_n), .i_power_down_n(pd_n), .o_wiper_code(code),
        .o_tap_select(taps), .o_top_terminal_open(top_open), .o_wiper_to_bottom(to_bottom));
    swlc_host_model swlc_host_model_inst (
        .i_clk(clk), .i_chain_level(sdo_oe_n ? 1'b1 : chain_word_out), .o_sclk(sclk),
        .o_cs_n(cs_n), .o_serial_word_in(serial_word_in));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails = fails + 1;
            stop_test();
        end
    end

    // ==========================================
    // Checking helpers
    task automatic check(input logic ok, input string what);
        samples_checked++;
        if (!ok) begin
            fails++;
            $display("FAIL %0t %s", $time, what);
        end
    endtask

    task automatic check_all;
        for (int c = 0; c < 4; c++) begin
            check(code[c] === exp[c], "code");
            check(taps[c] === (pd_n ? 256'h1 << exp[c] : 256'h0), "tap");
        end
    endtask

    task automatic put(input int ch, input swlc_code_t v, input logic junk);
        swlc_host_model_inst.send_word({ch[1:0], v}, junk);
        exp[ch] = v;
        for (int n = 0; n < 30 && code[ch] !== v; n++) @(posedge clk);
    endtask

    // ==========================================
    // Scenarios
    task automatic t_init;
        for (int c = 0; c < 4; c++) exp[c] = `SWLC_MIDSCALE;
        check_all();
        check(top_open === 4'hf && to_bottom === 4'hf && sdo_oe_n === 1'b1, "shutdown");
        mid_n <= 1'b1;
        pd_n <= 1'b1;
        repeat (6) @(posedge clk);
        check_all();
        check(top_open === 4'h0 && to_bottom === 4'h0, "run");
    endtask

    task automatic t_channels;
        int order [4] = '{3, 0, 2, 1};
        swlc_code_t val [4] = '{8'hff, 8'h00, 8'h5a, 8'h01};
        for (int i = 0; i < 4; i++) begin
            put(order[i], val[i], 1'b0);
            check_all();
        end
    endtask

    task automatic t_chain;
        put(2, 8'h3c, 1'b1);
        check_all();
        check(swlc_host_model_inst.chain_q === swlc_host_model_inst.JUNK, "chain");
    endtask

    task automatic t_shutdown;
        pd_n <= 1'b0;
        repeat (6) @(posedge clk);
        check(top_open === 4'hf && to_bottom === 4'hf, "off");
        put(1, 8'h77, 1'b0);
        check(swlc_host_model_inst.chain_q === 10'h3ff && sdo_oe_n === 1'b1, "sdo");
        check_all();
        pd_n <= 1'b1;
        repeat (6) @(posedge clk);
        check_all();
    endtask

    task automatic t_priority;
        mid_n <= 1'b0;
        put(0, 8'h11, 1'b0);
        for (int c = 0; c < 4; c++) exp[c] = `SWLC_MIDSCALE;
        check_all();
        mid_n <= 1'b1;
        repeat (6) @(posedge clk);
        check_all();
    endtask

    task automatic t_reset;
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        for (int c = 0; c < 4; c++) check(code[c] === exp[c], "reset code");
        check(top_open === 4'hf && sdo_oe_n === 1'b1, "reset pins");
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        check_all();
        check(top_open === 4'h0 && to_bottom === 4'h0, "reset run");
        put(3, 8'hc3, 1'b0);
        check_all();
    endtask

    task automatic stop_test;
        $display("fails=%0d samples_checked=%0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        reset_n = 1'b0;
        mid_n = 1'b0;
        pd_n = 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        t_init();
        t_channels();
        t_chain();
        t_shutdown();
        t_priority();
        t_reset();
        stop_test();
    end
endmodule // tb_top
